// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import tsi_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] cc;
    logic [7:0] lvl;
    logic [15:0] seed;
    tsi_act_t act;
    int miscompares, checks, cyc, idx;
    logic [3:0] codes [9] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hd, 4'he};

    tsi_field_model tsi_field_model_i (.contact_closed(cc), .seq_lvl(lvl));
    tsi_inputs tsi_inputs_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .contact_closed(cc), .first_lost(lvl[0]),
        .seq_transfer_request(lvl[1]), .seq_to_backup(lvl[2]), .internal_load_test(lvl[3]),
        .automatic_selector_position(lvl[4]), .controller_ok(lvl[5]),
        .first_sensed_avail(lvl[6]), .second_sensed_avail(lvl[7]), .act(act));

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic obs(input tsi_act_t a, input logic [3:0] c);
        case (c)
            4'h2: return a.retransfer_hold;
            4'h3: return a.block_to_second;
            4'h5: return a.second_preferred;
            4'h6: return a.skip_settle_first;
            4'h7: return a.skip_settle_second;
            4'h8: return a.alarm_code[0];
            4'h9: return a.alarm_code[1];
            4'hd: return a.first_avail;
            default: return a.second_avail;
        endcase
    endfunction
    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(negedge core_clk);
        while (pready !== 1'b1) @(negedge core_clk);
        rd = prdata;
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic map1(input int i, input logic [3:0] c);
        apb(1, TSI_OFF_FN_LO, i < 8 ? 32'(c) << (4 * i) : 32'h0000_0000);
        apb(1, TSI_OFF_FN_HI, i >= 8 ? 32'(c) << (4 * (i - 8)) : 32'h0000_0000);
    endtask
    // drive a contact or a sequencer level, then settle
    task automatic put(input logic l, input int i, input logic v);
        @(posedge core_clk);
        if (l)
            tsi_field_model_i.lvl[i] <= v;
        else
            tsi_field_model_i.want[i] <= v;
        @(negedge core_clk);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ----
    // sequence
    // ----
    initial begin
        rst = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        miscompares = 0;
        checks = 0;
        cyc = 0;
        seed = 16'h2fea;
        repeat (2) @(posedge core_clk);
        rst <= 0;
        apb(0, TSI_OFF_POL, 0);
        chk32("pol", {18'h0_0000, TSI_POL_RST}, rd);
        apb(1, 12'h100, 32'hffff_ffff);
        apb(0, 12'h100, 0);
        chk32("unmapped", 32'h0000_0000, rd);
        chk1("err", 0, pslverr);
        foreach (codes[k]) begin
            seed = lfsr(seed);
            idx = (k == 0) ? 13 : int'(seed % 14);
            seed = lfsr(seed);
            apb(1, TSI_OFF_POL, {18'h0_0000, seed[13:0]});
            tsi_field_model_i.nc <= seed[13:0];
            map1(idx, codes[k]);
            for (int v = 0; v < 2; v++) begin
                put(0, idx, v[0]);
                chk1("fn", v[0], obs(act, codes[k]));
            end
            put(0, idx, 0);
        end
        apb(1, TSI_OFF_POL, 0);
        tsi_field_model_i.nc <= 14'h0000;
        apb(1, TSI_OFF_FN_LO, 32'h0000_8000);
        apb(1, TSI_OFF_FN_HI, 32'h0008_0000);
        put(0, 12, 1);
        chk1("alarm", 1, act.alarm_code[0]);
        chk1("flash", 1, act.fault_led_flash);
        chk1("avail", 0, act.product_available);
        chk1("zero", 0, act.go_zero);
        put(0, 12, 0);
        put(0, 3, 1);
        chk1("alarm", 1, act.alarm_code[0]);
        put(0, 3, 0);
        chk1("alarm", 0, act.alarm_code[0]);
        chk1("avail", 1, act.product_available);
        map1(0, 4'h1);
        put(0, 0, 1);
        put(1, 0, 1);
        chk1("gen", 1, act.gen_start);
        chk1("pos", 0, act.pos_cmd_en);
        put(0, 0, 0);
        put(1, 0, 0);
        map1(0, 4'h4);
        put(0, 0, 1);
        chk1("ret", 0, act.retransfer_command);
        apb(1, TSI_OFF_CFG, 32'h0000_0001);
        @(negedge core_clk);
        chk1("ret", 1, act.retransfer_command);
        put(0, 0, 0);
        apb(1, TSI_OFF_CFG, 0);
        apb(1, TSI_OFF_FN_LO, 32'h0000_00c2);
        put(0, 1, 1);
        chk1("hold", 0, act.hold_second);
        put(0, 0, 1);
        chk1("hold", 1, act.hold_second);
        put(0, 0, 0);
        put(0, 1, 0);
        apb(1, TSI_OFF_FN_LO, 32'h0000_00fa);
        for (int m = 0; m < 3; m++) begin
            put(0, 0, 1);
            @(negedge core_clk);
            chk1("zero", 1, act.go_zero);
            put(0, 0, 0);
            chk1("flt", 1, act.fault_code[0]);
            if (m == 0)
                apb(1, TSI_OFF_CMD, 32'h0000_0002);
            if (m == 1) begin
                put(0, 1, 1);
                put(0, 1, 0);
            end
            if (m == 2) begin
                put(1, 4, 0);
                put(1, 4, 1);
            end
            repeat (2) @(negedge core_clk);
            chk1("clr", 0, act.fault_code[0]);
        end
        map1(0, 4'h0);
        apb(1, TSI_OFF_CFG, 32'h0000_0008);
        put(0, 0, 1);
        chk1("shed", 0, act.skip_shed_delay);
        apb(1, TSI_OFF_CFG, 32'h0000_000c);
        @(negedge core_clk);
        chk1("shed", 1, act.skip_shed_delay);
        put(0, 0, 0);
        put(1, 1, 1);
        put(1, 2, 1);
        chk1("lsc", 1, act.shed_before_transfer_output);
        put(0, 0, 1);
        chk1("lsc", 0, act.shed_before_transfer_output);
        print_verdict();
    end
endmodule

// ===== bench/tsi_field_model.sv
`timescale 1ns/10ps
module tsi_field_model (
    // field contacts, 1 = closed
    output logic [tsi_pkg::TSI_N_IN-1:0] contact_closed,
    // sequencer levels
    output logic [7:0] seq_lvl
);
    import tsi_pkg::*;
    // ----
    // wished activity, wiring polarity, levels
    // ----
    logic [TSI_N_IN-1:0] want;
    logic [TSI_N_IN-1:0] nc;
    logic [7:0] lvl;
    initial begin
        want = 14'h0000;
        nc = 14'h0000;
        lvl = 8'h30;
    end
    // nc contact opens when active
    assign contact_closed = want ^ nc;
    assign seq_lvl = lvl;
endmodule

// ===== verilog/tsi_inputs.sv
`timescale 1ns/10ps
module tsi_inputs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // contacts, 1 = closed
    input wire logic [tsi_pkg::TSI_N_IN-1:0] contact_closed,
    // sequencer status
    input wire logic first_lost,
    input wire logic seq_transfer_request,
    input wire logic seq_to_backup,
    input wire logic internal_load_test,
    input wire logic automatic_selector_position,
    input wire logic controller_ok,
    input wire logic first_sensed_avail,
    input wire logic second_sensed_avail,
    // actions to sequencer
    output tsi_pkg::tsi_act_t act
);
    import tsi_pkg::*;

    // ----------------------------------------
    // polarity and function decode
    // ----------------------------------------
    tsi_state_t st_ff, nxt_st;
    logic [TSI_N_IN-1:0] in_active;
    logic [15:0] fn_hit;
    logic shed_skip_ok;
    logic apb_wr, apb_rd;

    assign in_active = contact_closed ^ st_ff.pol;

    // any input mapped to a function may trigger it
    always_comb begin
        fn_hit = 16'h0000;
        for (int i = 0; i < TSI_N_IN; i++) begin
            if (in_active[i]) begin
                fn_hit[st_ff.fn[i*4 +: 4]] = 1'b1;
            end
        end
    end

    // skip on code zero only when the shed output is assigned and selected
    assign shed_skip_ok = st_ff.cfg[TSI_CFG_SHED_OUT] & st_ff.cfg[TSI_CFG_SHED_SKIP_SEL];

    // ----------------------------------------
    // action outputs
    // ----------------------------------------
    logic any_fault, any_alarm, ext_load_test, on_load;
    assign any_fault = |st_ff.flt_lat;
    assign any_alarm = fn_hit[TSI_FN_ALARM_FIRST] | fn_hit[TSI_FN_ALARM_SECOND];
    assign ext_load_test = fn_hit[TSI_FN_LOAD_TEST];
    assign on_load = ext_load_test | internal_load_test;

    always_comb begin
        act.gen_start = first_lost | on_load | fn_hit[TSI_FN_NO_LOAD_TEST];
        act.pos_cmd_en = ~fn_hit[TSI_FN_AUTO_BLOCK];
        act.go_zero = any_fault;
        act.hold_second = on_load & fn_hit[TSI_FN_HOLD_BACKUP];
        act.block_to_second = fn_hit[TSI_FN_NO_LOAD_TEST] & ~ext_load_test;
        act.retransfer_hold = ext_load_test;
        act.retransfer_command = fn_hit[TSI_FN_RETURN_PREF] & st_ff.cfg[TSI_CFG_RET_EN];
        act.second_preferred = fn_hit[TSI_FN_SECOND_PREF] | st_ff.cfg[TSI_CFG_PREF2];
        act.skip_settle_first = fn_hit[TSI_FN_SETTLE_FIRST];
        act.skip_settle_second = fn_hit[TSI_FN_SETTLE_SECOND];
        act.first_avail = first_sensed_avail | fn_hit[TSI_FN_FORCE_FIRST];
        act.second_avail = second_sensed_avail | fn_hit[TSI_FN_FORCE_SECOND];
        act.skip_shed_delay = shed_skip_ok & fn_hit[TSI_FN_SHED_SKIP];
        act.shed_before_transfer_output = st_ff.cfg[TSI_CFG_SHED_OUT] & seq_transfer_request
            & seq_to_backup & ~act.skip_shed_delay;
        act.fault_led_flash = any_fault | any_alarm;
        act.alarm_code = {fn_hit[TSI_FN_ALARM_SECOND], fn_hit[TSI_FN_ALARM_FIRST]};
        act.fault_code = st_ff.flt_lat;
        act.product_available = controller_ok & ~any_fault & ~any_alarm
            & ~fn_hit[TSI_FN_AUTO_BLOCK];
    end

    // ----------------------------------------
    // apb and state update
    // ----------------------------------------
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & ~penable & ~pwrite;

    always_comb begin
        logic clr;
        logic sel_cycle;
        clr = 1'b0;
        sel_cycle = 1'b0;
        nxt_st = st_ff;
        nxt_st.pready = psel & ~penable;
        if (apb_wr) begin
            case (paddr)
                TSI_OFF_POL: nxt_st.pol = pwdata[13:0];
                TSI_OFF_CFG: nxt_st.cfg = pwdata[3:0];
                TSI_OFF_FN_LO: nxt_st.fn[31:0] = pwdata;
                TSI_OFF_FN_HI: nxt_st.fn[63:32] = {8'h00, pwdata[23:0]};
                TSI_OFF_CMD: clr = pwdata[TSI_CMD_FLT_CLR];
                default: ;
            endcase
        end
        if (apb_rd) begin
            case (paddr)
                TSI_OFF_POL: nxt_st.prdata = {18'h0_0000, st_ff.pol};
                TSI_OFF_CFG: nxt_st.prdata = {28'h000_0000, st_ff.cfg};
                TSI_OFF_FN_LO: nxt_st.prdata = st_ff.fn[31:0];
                TSI_OFF_FN_HI: nxt_st.prdata = st_ff.fn[63:32];
                TSI_OFF_ACT: nxt_st.prdata = {16'h0000, fn_hit};
                TSI_OFF_STAT: nxt_st.prdata = {26'h000_0000, act.product_available,
                    act.alarm_code, st_ff.flt_lat, 1'b0} >> 1;
                TSI_OFF_RAW: nxt_st.prdata = {18'h0_0000, in_active};
                default: nxt_st.prdata = 32'h0000_0000;
            endcase
        end
        // selector cycle auto -> manual -> auto clears faults
        nxt_st.sel_seen_man[0] = ~automatic_selector_position;
        sel_cycle = st_ff.sel_seen_man[0] & automatic_selector_position;
        // bit 1 keeps the last fault-clear level for edge detection
        nxt_st.sel_seen_man[1] = fn_hit[TSI_FN_FAULT_CLEAR];
        clr = clr | sel_cycle | (fn_hit[TSI_FN_FAULT_CLEAR] & ~st_ff.sel_seen_man[1]);
        // an active fault input, new or held, wins over a clear
        for (int s = 0; s < 2; s++) begin
            if (fn_hit[TSI_FN_FAULT_FIRST + s]) begin
                nxt_st.flt_lat[s] = 1'b1;
            end else if (clr) begin
                nxt_st.flt_lat[s] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '{pol: TSI_POL_RST, cfg: TSI_CFG_RST, fn: {TSI_FN_RST, TSI_FN_RST},
                       flt_lat: 2'b00, sel_seen_man: 2'b00, prdata: 32'h0000_0000,
                       pready: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = psel & penable & st_ff.pready;
    assign pslverr = 1'b0;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_fault_rise;
        fn_hit[TSI_FN_FAULT_FIRST] && !$past(fn_hit[TSI_FN_FAULT_FIRST]);
    endsequence
    sequence s_fault2_rise;
        fn_hit[TSI_FN_FAULT_SECOND] && !$past(fn_hit[TSI_FN_FAULT_SECOND]);
    endsequence
    sequence s_clr_rise;
        fn_hit[TSI_FN_FAULT_CLEAR] && !$past(fn_hit[TSI_FN_FAULT_CLEAR]) && !fn_hit[TSI_FN_FAULT_FIRST];
    endsequence
    sequence s_sel_back;
        !automatic_selector_position ##1 automatic_selector_position && !fn_hit[TSI_FN_FAULT_FIRST];
    endsequence
    sequence s_cmd_clear;
        apb_wr && paddr == TSI_OFF_CMD && pwdata[TSI_CMD_FLT_CLR] && !fn_hit[TSI_FN_FAULT_FIRST];
    endsequence
    sequence s_pol_write;
        apb_wr && paddr == TSI_OFF_POL;
    endsequence

    // ----------------------------------------
    // fault and alarm checks
    // ----------------------------------------
    a_fault_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        s_fault_rise |=> act.go_zero && act.fault_code[0])
        else $error("fault input did not send switch to zero");
    a_fault2_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        s_fault2_rise |=> act.go_zero && act.fault_code[1])
        else $error("second fault did not send switch to zero");
    a_zero_idle: assert property (
        @(posedge core_clk) disable iff (rst)
        !any_fault |-> !act.go_zero)
        else $error("zero position without fault");
    a_fault_latch: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(fn_hit[TSI_FN_FAULT_FIRST]) && !apb_wr && automatic_selector_position
        && !fn_hit[TSI_FN_FAULT_CLEAR] |-> act.fault_code[0])
        else $error("fault released without a clear");
    a_cmd_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        s_cmd_clear |=> !act.fault_code[0])
        else $error("software clear did not clear fault");
    a_input_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        s_clr_rise |=> !act.fault_code[0])
        else $error("clear input did not clear fault");
    a_sel_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        s_sel_back |=> !act.fault_code[0])
        else $error("selector cycle did not clear fault");
    a_fault_flash: assert property (
        @(posedge core_clk) disable iff (rst)
        any_fault |-> act.fault_led_flash)
        else $error("fault without flashing indicator");
    a_alarm_follow: assert property (
        @(posedge core_clk) disable iff (rst)
        act.alarm_code[0] == fn_hit[TSI_FN_ALARM_FIRST])
        else $error("alarm code does not follow input");
    a_alarm_flash: assert property (
        @(posedge core_clk) disable iff (rst)
        any_alarm |-> act.fault_led_flash)
        else $error("alarm without flashing indicator");
    a_alarm_unavail: assert property (
        @(posedge core_clk) disable iff (rst)
        any_alarm |-> !act.product_available && !act.go_zero || any_fault)
        else $error("alarm left product available");

    // ----------------------------------------
    // function checks
    // ----------------------------------------
    a_block_gen: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_AUTO_BLOCK] && first_lost |-> !act.pos_cmd_en && act.gen_start)
        else $error("auto block mishandled");
    a_gen_block: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_AUTO_BLOCK] |-> !act.pos_cmd_en)
        else $error("auto block left position commands on");
    a_pos_free: assert property (
        @(posedge core_clk) disable iff (rst)
        !fn_hit[TSI_FN_AUTO_BLOCK] |-> act.pos_cmd_en)
        else $error("position commands blocked without input");
    a_gen_no_load: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_NO_LOAD_TEST] |-> act.gen_start)
        else $error("no-load test did not start generator");
    a_gen_load_test: assert property (
        @(posedge core_clk) disable iff (rst)
        on_load |-> act.gen_start)
        else $error("load test did not start generator");
    a_block_load: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_NO_LOAD_TEST] && !ext_load_test |-> act.block_to_second)
        else $error("no-load test let load move");
    a_ret_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        ext_load_test |-> act.retransfer_hold)
        else $error("load test did not hold retransfer");
    a_ret_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        !st_ff.cfg[TSI_CFG_RET_EN] |-> !act.retransfer_command)
        else $error("retransfer without option");
    a_ret_pass: assert property (
        @(posedge core_clk) disable iff (rst)
        st_ff.cfg[TSI_CFG_RET_EN] && fn_hit[TSI_FN_RETURN_PREF] |-> act.retransfer_command)
        else $error("retransfer input ignored with option set");
    a_pref_input: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_SECOND_PREF] |-> act.second_preferred)
        else $error("priority input ignored");
    a_pref_default: assert property (
        @(posedge core_clk) disable iff (rst)
        !fn_hit[TSI_FN_SECOND_PREF] && !st_ff.cfg[TSI_CFG_PREF2] |-> !act.second_preferred)
        else $error("source 2 preferred without cause");
    a_settle_first: assert property (
        @(posedge core_clk) disable iff (rst)
        act.skip_settle_first == fn_hit[TSI_FN_SETTLE_FIRST])
        else $error("first settle skip wrong");
    a_settle_second: assert property (
        @(posedge core_clk) disable iff (rst)
        act.skip_settle_second == fn_hit[TSI_FN_SETTLE_SECOND])
        else $error("second settle skip wrong");
    a_hold_second: assert property (
        @(posedge core_clk) disable iff (rst)
        ext_load_test && fn_hit[TSI_FN_HOLD_BACKUP] |-> act.hold_second
        && act.retransfer_hold)
        else $error("hold on backup not applied");
    a_hold_internal: assert property (
        @(posedge core_clk) disable iff (rst)
        internal_load_test && fn_hit[TSI_FN_HOLD_BACKUP] |-> act.hold_second)
        else $error("hold ignored during internal test");
    a_force_avail: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_FORCE_SECOND] |-> act.second_avail)
        else $error("forced availability ignored");
    a_force_first: assert property (
        @(posedge core_clk) disable iff (rst)
        fn_hit[TSI_FN_FORCE_FIRST] |-> act.first_avail)
        else $error("forced first availability ignored");

    // ----------------------------------------
    // input mapping checks
    // ----------------------------------------
    a_builtin_map: assert property (
        @(posedge core_clk) disable iff (rst)
        in_active[0] |-> fn_hit[st_ff.fn[3:0]])
        else $error("built-in input did not reach its function");
    a_multi_map: assert property (
        @(posedge core_clk) disable iff (rst)
        in_active[13] |-> fn_hit[st_ff.fn[55:52]])
        else $error("add-on input did not reach its function");
    a_polarity: assert property (
        @(posedge core_clk) disable iff (rst)
        st_ff.pol[0] |-> in_active[0] == !contact_closed[0])
        else $error("normally closed polarity wrong");
    a_no_polarity: assert property (
        @(posedge core_clk) disable iff (rst)
        !st_ff.pol[1] |-> in_active[1] == contact_closed[1])
        else $error("normally open polarity wrong");
    a_pol_write: assert property (
        @(posedge core_clk) disable iff (rst)
        s_pol_write |=> st_ff.pol == $past(pwdata[13:0]))
        else $error("polarity write lost");

    // ----------------------------------------
    // shedding and availability checks
    // ----------------------------------------
    a_shed_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        !st_ff.cfg[TSI_CFG_SHED_OUT] |-> !act.skip_shed_delay
        && !act.shed_before_transfer_output)
        else $error("shed function without shed output");
    a_shed_skip: assert property (
        @(posedge core_clk) disable iff (rst)
        shed_skip_ok && fn_hit[TSI_FN_SHED_SKIP] |-> act.skip_shed_delay)
        else $error("shed skip input ignored");
    a_shed_before: assert property (
        @(posedge core_clk) disable iff (rst)
        st_ff.cfg[TSI_CFG_SHED_OUT] && seq_transfer_request && seq_to_backup
        && !act.skip_shed_delay |-> act.shed_before_transfer_output)
        else $error("no shedding before backup transfer");
    a_shed_backup: assert property (
        @(posedge core_clk) disable iff (rst)
        !seq_to_backup |-> !act.shed_before_transfer_output)
        else $error("shedding without backup transfer");
    a_avail_fault: assert property (
        @(posedge core_clk) disable iff (rst)
        any_fault || !controller_ok |-> !act.product_available)
        else $error("product available while not ready");

endmodule

// ===== verilog/tsi_pkg.sv
package tsi_pkg;

    // ----------------------------------------
    // input counts and function codes
    // ----------------------------------------
    localparam int TSI_N_BUILTIN = 6;
    localparam int TSI_N_ADDON = 8;
    localparam int TSI_N_IN = 14;
    localparam int TSI_FW = 4;

    typedef enum logic [3:0] {
        TSI_FN_NONE,
        TSI_FN_AUTO_BLOCK,
        TSI_FN_LOAD_TEST,
        TSI_FN_NO_LOAD_TEST,
        TSI_FN_RETURN_PREF,
        TSI_FN_SECOND_PREF,
        TSI_FN_SETTLE_FIRST,
        TSI_FN_SETTLE_SECOND,
        TSI_FN_ALARM_FIRST,
        TSI_FN_ALARM_SECOND,
        TSI_FN_FAULT_FIRST,
        TSI_FN_FAULT_SECOND,
        TSI_FN_HOLD_BACKUP,
        TSI_FN_FORCE_FIRST,
        TSI_FN_FORCE_SECOND,
        TSI_FN_FAULT_CLEAR
    } tsi_fn_t;
    localparam logic [3:0] TSI_FN_SHED_SKIP = 4'h0;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] TSI_OFF_POL = 12'h000;
    localparam logic [11:0] TSI_OFF_CFG = 12'h004;
    localparam logic [11:0] TSI_OFF_FN_LO = 12'h008;
    localparam logic [11:0] TSI_OFF_FN_HI = 12'h00c;
    localparam logic [11:0] TSI_OFF_CMD = 12'h010;
    localparam logic [11:0] TSI_OFF_ACT = 12'h014;
    localparam logic [11:0] TSI_OFF_STAT = 12'h018;
    localparam logic [11:0] TSI_OFF_RAW = 12'h01c;

    // cfg fields
    localparam int TSI_CFG_RET_EN = 0;
    localparam int TSI_CFG_PREF2 = 1;
    localparam int TSI_CFG_SHED_OUT = 2;
    localparam int TSI_CFG_SHED_SKIP_SEL = 3;
    // cmd fields (write one)
    localparam int TSI_CMD_RETRANSFER_COMMAND = 0;
    localparam int TSI_CMD_FLT_CLR = 1;

    localparam logic [13:0] TSI_POL_RST = 14'h0000;
    localparam logic [3:0] TSI_CFG_RST = 4'h0;
    localparam logic [31:0] TSI_FN_RST = 32'h0000_0000;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [13:0] pol;
        logic [3:0] cfg;
        logic [63:0] fn;
        logic [1:0] flt_lat;
        logic [1:0] sel_seen_man;
        logic [31:0] prdata;
        logic pready;
    } tsi_state_t;

    typedef struct packed {
        logic gen_start;
        logic pos_cmd_en;
        logic go_zero;
        logic hold_second;
        logic block_to_second;
        logic retransfer_hold;
        logic retransfer_command;
        logic second_preferred;
        logic skip_settle_first;
        logic skip_settle_second;
        logic first_avail;
        logic second_avail;
        logic skip_shed_delay;
        logic shed_before_transfer_output;
        logic fault_led_flash;
        logic [1:0] alarm_code;
        logic [1:0] fault_code;
        logic product_available;
    } tsi_act_t;

endpackage
